// ===== inc/fbb_cfg_if.sv
// Interface carrying one blanking configuration between modules.
`timescale 1ns/1ps
`default_nettype none
interface fbb_cfg_if #(
  parameter int N = 32
);
  logic [N-1:0]      mask;  // Set bit: beam is hidden.
  logic [N-1:0]      move;  // Set bit: its area may move.
  fbb_pkg::fbb_mode_t mode; // Plain or edge tolerant blanking.

  // Owner of the configuration registers.
  modport src (output mask, output move, output mode);
  // Reader of the configuration.
  modport sink (input mask, input move, input mode);
endinterface
`default_nettype wire

// ===== inc/fbb_consts.svh
// Constants for the fixed beam blanking evaluation block.
`ifndef FBB_CONSTS_SVH
`define FBB_CONSTS_SVH

// =====================================================================
// Beam field geometry
// Default number of beams in the curtain; a plain default.
`define FBB_NUM_BEAMS 32
// Least field size the evaluation logic can serve.
`define FBB_MIN_BEAMS 4
// Clear beams needed at one end: the sync beam and its neighbour.
`define FBB_SYNC_CLEAR_BEAMS 2

// =====================================================================
// Blanking geometry
// Smallest object that edge tolerance accepts, in beams.
`define FBB_MIN_OBJ_BEAMS 2
// Edge tolerance, in beams.
`define FBB_EDGE_TOL 1
// Least gap between hidden areas when no object moves.
`define FBB_GAP_STILL 1

// =====================================================================
// Reset values
`define FBB_MASK_RST '0
`define FBB_MOVE_RST '0

`endif

// ===== inc/fbb_pkg.sv
// Types shared by the fixed beam blanking evaluation block.
`default_nettype none
package fbb_pkg;
  // Blanking variant selected by the configuration.
  typedef enum logic {
    FBB_MODE_FIXED,
    FBB_MODE_EDGE
  } fbb_mode_t;

  // Operating state of the evaluation.
  typedef enum logic [1:0] {
    FBB_ST_NOCFG,
    FBB_ST_RUN,
    FBB_ST_ERROR
  } fbb_state_t;
endpackage
`default_nettype wire

// ===== rtl/fbb_blanking_eval.sv
// Top of the fixed beam blanking evaluation for the light receiver.
//
// Function
// R1 - Interrupted unhidden beam switches outputs OFF.
// R2 - Uncovered hidden beam enters error, outputs OFF.
// R3 - Reject masks hiding sync beam and neighbour.
// R4 - Plain mode: areas separated by one beam.
// R5 - Any number of hidden areas is allowed.
// R6 - Mask comes from teach-in or link write.
// R7 - Edge mode tolerates one beam boundary deviation.
// R8 - Edge mode objects need two beams minimum.
// R9 - Only one deviation per object is tolerated.
// R10 - Edge gaps: one, two or three beams.
// R11 - Plain mode growth reports penetration, not error.
// R12 - Plain mode shift or shrink gives error.
// R13 - Merged objects switch OFF with error.
// R14 - Hidden beams excluded from penetration evaluation.
// R15 - Evaluate once per scan; ON only clean.
`timescale 1ns/1ps
`default_nettype none
`include "fbb_consts.svh"
module fbb_blanking_eval #(
  parameter int NUM_BEAMS = `FBB_NUM_BEAMS
) (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic                 SCAN_VALID,
  input  wire logic [NUM_BEAMS-1:0] SCAN_BEAMS,
  input  wire logic                 TEACH_REQ,
  input  wire logic                 LINK_WR,
  input  wire logic [NUM_BEAMS-1:0] LINK_MASK,
  input  wire logic [NUM_BEAMS-1:0] LINK_MOVE,
  input  wire fbb_pkg::fbb_mode_t   LINK_MODE,
  input  wire logic                 ERROR_ACK,
  output logic                      SAFETY_SWITCH_OUTPUTS,
  output logic                      PENETRATION,
  output logic                      ERROR_STATE,
  output logic                      RESULT_VALID,
  output logic                      CFG_VALID,
  output logic                      CFG_REJECT
);
  import fbb_pkg::*;

  // =====================================================================
  // Elaboration check
  // The sync beam test looks at two beams at each end of the field.
  if (NUM_BEAMS < `FBB_MIN_BEAMS) begin : g_bad_size
    $error("NUM_BEAMS is too small for the blanking logic");
  end

  // =====================================================================
  // Declarations
  fbb_cfg_if #(.N(NUM_BEAMS)) cand_if ();  // Configuration under test.
  fbb_cfg_if #(.N(NUM_BEAMS)) act_if ();   // Configuration in force.

  logic [NUM_BEAMS-1:0] scan_beams;  // Beam pattern of the last scan.
  logic                 scan_pend;   // Scan captured, not yet judged.
  logic                 cand_pend;   // Candidate waits for its check.
  logic                 cfg_ok;      // Checker verdict on the candidate.
  logic                 scan_pen;    // Penetration seen in this scan.
  logic                 scan_err;    // Error condition seen in this scan.
  logic                 act_valid;   // Active configuration was accepted.
  logic                 commit;      // Candidate accepted this cycle.
  logic                 reject;      // Candidate refused this cycle.
  fbb_state_t           state;       // Operating state.
  fbb_state_t           next_state;  // Operating state for next cycle.

  assign commit = cand_pend && cfg_ok;
  assign reject = cand_pend && !cfg_ok;

  // =====================================================================
  // Sub-blocks
  // The checker only ever sees the candidate, so a bad write can never
  // reach the evaluator before it has been judged.
  fbb_cfg_check #(.N(NUM_BEAMS)) u_check (
    .cfg    (cand_if.sink),
    .cfg_ok (cfg_ok)
  );

  // The evaluator judges the captured scan against the active areas.
  fbb_scan_eval #(.N(NUM_BEAMS)) u_eval (
    .cfg   (act_if.sink),
    .beams (scan_beams),
    .pen   (scan_pen),
    .err   (scan_err)
  );

  // =====================================================================
  // Scan capture
  // Each scan is latched whole, so the judgement never mixes two scans.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      scan_beams <= '0;
      scan_pend  <= 1'b0;
    end else begin
      scan_pend <= SCAN_VALID;  // R15
      if (SCAN_VALID) begin
        scan_beams <= SCAN_BEAMS;
      end
    end
  end

  // =====================================================================
  // Candidate configuration
  // A link write wins over a teach-in in the same cycle, because the
  // external master states its intent explicitly. Teach-in takes the
  // last captured scan as the mask and keeps the present mode; taught
  // areas are marked as fixed.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cand_if.mask <= `FBB_MASK_RST;
      cand_if.move <= `FBB_MOVE_RST;
      cand_if.mode <= FBB_MODE_FIXED;
      cand_pend    <= 1'b0;
    end else if (LINK_WR) begin
      cand_if.mask <= LINK_MASK;  // R6
      cand_if.move <= LINK_MOVE;
      cand_if.mode <= LINK_MODE;
      cand_pend    <= 1'b1;
    end else if (TEACH_REQ) begin
      cand_if.mask <= scan_beams;  // R6
      cand_if.move <= `FBB_MOVE_RST;
      cand_if.mode <= act_if.mode;
      cand_pend    <= 1'b1;
    end else begin
      cand_pend <= 1'b0;
    end
  end

  // =====================================================================
  // Active configuration
  // An accepted candidate replaces the areas in force. A refused one
  // withdraws them: keeping an old mask after a failed change would
  // leave blanking the operator no longer expects.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      act_if.mask <= `FBB_MASK_RST;
      act_if.move <= `FBB_MOVE_RST;
      act_if.mode <= FBB_MODE_FIXED;
      act_valid   <= 1'b0;
    end else if (commit) begin
      act_if.mask <= cand_if.mask;
      act_if.move <= cand_if.move;
      act_if.mode <= cand_if.mode;
      act_valid   <= 1'b1;
    end else if (reject) begin
      act_valid <= 1'b0;  // R3 R4 R10
    end
  end

  // =====================================================================
  // State decision
  // The error state holds until an acknowledge or a refused candidate. An error
  // in the scan judged in the same cycle as an acknowledge wins over it.
  always_comb begin
    next_state = state;
    case (state)
      FBB_ST_NOCFG: begin
        // Without accepted areas the field cannot be judged safely.
        if (commit) begin
          next_state = FBB_ST_RUN;
        end
      end
      FBB_ST_RUN: begin
        if (reject) begin
          next_state = FBB_ST_NOCFG;
        end else if (scan_pend && scan_err) begin
          next_state = FBB_ST_ERROR;  // R2 R12 R13
        end
      end
      FBB_ST_ERROR: begin
        if (reject) begin
          next_state = FBB_ST_NOCFG;
        end else if (ERROR_ACK && !(scan_pend && scan_err)) begin
          next_state = act_valid ? FBB_ST_RUN : FBB_ST_NOCFG;
        end
      end
      default: begin
        next_state = FBB_ST_NOCFG;
      end
    endcase
  end

  // State register.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state <= FBB_ST_NOCFG;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // Safety switching outputs
  // While running, the outputs change only when a scan has been judged, so they hold
  // their value between scans. Any state other than running forces OFF
  // at once, without waiting for the next scan.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      SAFETY_SWITCH_OUTPUTS <= 1'b0;
      PENETRATION           <= 1'b0;
    end else if (next_state != FBB_ST_RUN) begin
      SAFETY_SWITCH_OUTPUTS <= 1'b0;  // R2
      if (scan_pend) begin
        PENETRATION <= scan_pen;
      end
    end else if (scan_pend) begin
      // Hidden beams never reach the penetration term.
      SAFETY_SWITCH_OUTPUTS <= !scan_pen && !scan_err;  // R15 R14 R7
      PENETRATION           <= scan_pen;  // R1 R11
    end
  end

  // =====================================================================
  // Status outputs
  // Error shows every state that holds the outputs OFF by itself.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ERROR_STATE  <= 1'b1;
      RESULT_VALID <= 1'b0;
      CFG_VALID    <= 1'b0;
      CFG_REJECT   <= 1'b0;
    end else begin
      ERROR_STATE  <= (next_state != FBB_ST_RUN);
      RESULT_VALID <= scan_pend;
      CFG_VALID    <= commit || (act_valid && !reject);
      CFG_REJECT   <= reject;  // R3 R4 R10
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fbb_cfg_check.sv
// Validation of a candidate blanking configuration.
`timescale 1ns/1ps
`default_nettype none
`include "fbb_consts.svh"
module fbb_cfg_check #(
  parameter int N = `FBB_NUM_BEAMS
) (
  fbb_cfg_if.sink    cfg,
  output logic       cfg_ok
);
  import fbb_pkg::*;

  logic [N+1:0] mp; // Mask padded with a clear beam at each end.

  assign mp = {1'b0, cfg.mask, 1'b0};

  // =====================================================================
  // Geometry check
  // Walks the mask once. Areas are not counted at all, so any number of
  // separate areas passes as long as gaps, sizes and sync ends are in order.
  always_comb begin
    int  s;
    int  prev_end;
    int  need;
    logic have_prev;
    logic prev_mov;
    logic bad;
    s = 0;
    prev_end = 0;
    need = 0;
    have_prev = 1'b0;
    prev_mov = 1'b0;
    bad = 1'b0;
    // A sync beam and its neighbour must stay clear at one end.
    if (cfg.mask[1:0] != 2'b00 &&
        cfg.mask[N-1:N-2] != 2'b00) begin
      bad = 1'b1; // R3
    end
    for (int i = 0; i < N; i++) begin
      // Area start: check the gap to the previous area.
      if (mp[i+1] && !mp[i]) begin
        s = i;
        need = `FBB_GAP_STILL;
        if (cfg.mode == FBB_MODE_EDGE) begin
          need = need + int'(prev_mov) + int'(cfg.move[i]); // R10
        end
        if (have_prev && (i - prev_end - 1) < need) begin
          bad = 1'b1; // R4
        end
      end
      // Area end: edge mode needs objects of two beams or more.
      if (mp[i+1] && !mp[i+2]) begin
        if (cfg.mode == FBB_MODE_EDGE &&
            (i - s + 1) < `FBB_MIN_OBJ_BEAMS) begin
          bad = 1'b1; // R8
        end
        have_prev = 1'b1;
        prev_end = i;
        prev_mov = cfg.move[i];
      end
    end
    cfg_ok = !bad; // R5
  end
endmodule
`default_nettype wire

// ===== rtl/fbb_scan_eval.sv
// Evaluation of one beam pattern against the active hidden areas.
`timescale 1ns/1ps
`default_nettype none
`include "fbb_consts.svh"
module fbb_scan_eval #(
  parameter int N = `FBB_NUM_BEAMS
) (
  fbb_cfg_if.sink    cfg,
  input  wire logic [N-1:0] beams,
  output logic       pen,
  output logic       err
);
  import fbb_pkg::*;

  logic [N+1:0] mp; // Mask, padded with a clear beam at each end.
  logic [N+1:0] bp; // Interrupted beams, padded the same way.

  assign mp = {1'b0, cfg.mask, 1'b0};
  assign bp = {1'b0, beams, 1'b0};

  // =====================================================================
  // Pattern walk
  // One pass finds penetrations, merged objects and per-area deviations.
  always_comb begin
    int  s;
    int  unc;
    int  nar;
    int  ulo;
    int  uhi;
    int  glo;
    int  ghi;
    logic run;
    logic edge_m;
    s = 0;
    unc = 0;
    nar = 0;
    ulo = 0;
    uhi = 0;
    glo = 0;
    ghi = 0;
    run = 1'b0;
    pen = 1'b0;
    err = 1'b0;
    edge_m = (cfg.mode == FBB_MODE_EDGE);
    for (int i = 0; i < N; i++) begin
      // Unhidden beam interrupted; edge mode forgives one beam of margin.
      if (bp[i+1] && !mp[i+1]) begin
        if (!edge_m || !(mp[i] || mp[i+2])) begin // R7
          pen = 1'b1; // R1
        end
      end
      // Count hidden areas inside one interrupted run.
      if (bp[i+1]) begin
        if (!run) begin
          nar = 0;
        end
        if (mp[i+1] && !(run && mp[i])) begin
          nar = nar + 1;
        end
        if (nar > 1) begin
          err = 1'b1; // R13
        end
        run = 1'b1;
      end else begin
        run = 1'b0;
      end
      // Track uncovered beams of the current area.
      if (mp[i+1] && !mp[i]) begin
        s = i;
        unc = 0;
      end
      if (mp[i+1] && !bp[i+1]) begin
        unc = unc + 1;
      end
      // At the end of each area judge the object found there.
      if (mp[i+1] && !mp[i+2]) begin
        ulo = int'(!bp[s+1]);
        uhi = int'(!bp[i+1]);
        glo = int'(bp[s]);
        ghi = int'(bp[i+2]);
        if (!edge_m) begin
          if (unc > 0) begin
            err = 1'b1; // R2 R12
          end
        end else begin
          // Uncovered inside the area or at both ends.
          if (unc - ulo - uhi > 0 || (ulo + uhi) > `FBB_EDGE_TOL) begin
            err = 1'b1; // R9 R2
          end
          // Growth on both sides is a penetration, not a deviation.
          if (glo + ghi > `FBB_EDGE_TOL) begin
            pen = 1'b1; // R9
          end
          // Gap opened next to a grown edge splits the object.
          if ((ulo + glo) > 1 || (uhi + ghi) > 1) begin
            err = 1'b1; // R9
          end
          if ((i - s + 1) - unc + glo + ghi < `FBB_MIN_OBJ_BEAMS) begin
            err = 1'b1; // R8
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/fbb_blanking_eval_chk.sv
// Port checks for the blanking evaluation top.
`timescale 1ns/1ps
`default_nettype none
module fbb_blanking_eval_chk #(
  parameter int NUM_BEAMS = 32
) (
  input wire logic                 CLK,
  input wire logic                 NRST,
  input wire logic                 SCAN_VALID,
  input wire logic                 LINK_WR,
  input wire logic [NUM_BEAMS-1:0] LINK_MASK,
  input wire logic                 SAFETY_SWITCH_OUTPUTS,
  input wire logic                 PENETRATION,
  input wire logic                 ERROR_STATE,
  input wire logic                 RESULT_VALID,
  input wire logic                 CFG_VALID,
  input wire logic                 CFG_REJECT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ==========================================
  // Both ends hold a hidden beam among their two end beams.
  logic both_ends;
  assign both_ends = (|LINK_MASK[1:0]) &&
                     (|LINK_MASK[NUM_BEAMS-1:NUM_BEAMS-2]);
  // Answers arrive two edges after the request is taken.
  sequence judged_2;
    ##2 RESULT_VALID;
  endsequence
  sequence cfg_ans;
    ##2 (CFG_VALID ^ CFG_REJECT);
  endsequence
  // ==========================================
  // Assertions.
  chk_scan_answer: assert property (SCAN_VALID |-> judged_2)
    else $error("scan not judged two cycles later");
  chk_result_cause: assert property (
    RESULT_VALID |-> $past(SCAN_VALID, 2))
    else $error("result without a scan");
  chk_on_clean: assert property (SAFETY_SWITCH_OUTPUTS |->
    CFG_VALID && !ERROR_STATE && !PENETRATION)
    else $error("outputs ON while not clean");
  chk_rise_judged: assert property (
    $rose(SAFETY_SWITCH_OUTPUTS) |-> RESULT_VALID)
    else $error("outputs ON outside a judged scan");
  chk_pen_off: assert property (
    RESULT_VALID && PENETRATION |-> !SAFETY_SWITCH_OUTPUTS)
    else $error("outputs ON after penetration");
  chk_cfg_answer: assert property (LINK_WR |-> cfg_ans)
    else $error("link write not answered");
  chk_sync_reject: assert property (
    LINK_WR && both_ends |-> ##2 CFG_REJECT)
    else $error("mask hiding both sync ends accepted");
  chk_reject_state: assert property (CFG_REJECT |->
    !CFG_VALID && ERROR_STATE && !SAFETY_SWITCH_OUTPUTS)
    else $error("reject left config active");
endmodule
bind fbb_blanking_eval fbb_blanking_eval_chk #(
  .NUM_BEAMS(NUM_BEAMS)
) chk_u (
  .CLK(CLK), .NRST(NRST), .SCAN_VALID(SCAN_VALID), .LINK_WR(LINK_WR),
  .LINK_MASK(LINK_MASK), .SAFETY_SWITCH_OUTPUTS(SAFETY_SWITCH_OUTPUTS),
  .PENETRATION(PENETRATION), .ERROR_STATE(ERROR_STATE),
  .RESULT_VALID(RESULT_VALID), .CFG_VALID(CFG_VALID),
  .CFG_REJECT(CFG_REJECT)
);
`default_nettype wire

// ===== testbench/fbb_machine_model.sv
// Model of the machine safety circuit fed by the switching outputs.
`timescale 1ns/1ps
`default_nettype none
module fbb_machine_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic safety_out,
  output logic      motion_on
);
  // ==========================================
  // Motion runs only while the outputs are ON.
  // A real machine reacts one cycle late, so do we.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      motion_on <= 1'b0;
    end else begin
      motion_on <= safety_out;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the blanking evaluation top.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fbb_pkg::*;
  localparam int N = 16;      // Short field keeps patterns readable.
  localparam int LIMIT = 4000; // Cycles; the run needs about 100.
  logic         clk, nrst, scan_valid, teach_req, link_wr, error_ack;
  logic [N-1:0] scan_beams, link_mask, link_move;
  fbb_mode_t    link_mode;
  logic         safety, pen, err_st, res_v, cfg_v, cfg_rej, motion_on;
  int           num_errors, checks, cyc;
  fbb_blanking_eval #(.NUM_BEAMS(N)) dut_u (
    .CLK(clk), .NRST(nrst), .SCAN_VALID(scan_valid),
    .SCAN_BEAMS(scan_beams), .TEACH_REQ(teach_req), .LINK_WR(link_wr),
    .LINK_MASK(link_mask), .LINK_MOVE(link_move), .LINK_MODE(link_mode),
    .ERROR_ACK(error_ack), .SAFETY_SWITCH_OUTPUTS(safety),
    .PENETRATION(pen), .ERROR_STATE(err_st), .RESULT_VALID(res_v),
    .CFG_VALID(cfg_v), .CFG_REJECT(cfg_rej));
  fbb_machine_model machine_u (.clk(clk), .nrst(nrst),
    .safety_out(safety), .motion_on(motion_on));
  // ==========================================
  // Clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      final_report();
    end
  end
  // ==========================================
  // Shared tasks; cfg and scan start and end at a falling edge.
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(string name, logic exp, logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Candidate sent over the link. The answer is registered on the edge
  // after capture, and the reject pulse lasts one cycle only.
  task automatic cfg(logic [N-1:0] m, mv, fbb_mode_t md, logic ok);
    link_mask = m;
    link_move = mv;
    link_mode = md;
    link_wr = 1'b1;
    @(negedge clk);
    link_wr = 1'b0;
    link_mask = ~m; // Stale data must not be reused.
    @(negedge clk);
    chk("cfg_valid", ok, cfg_v);
    chk("cfg_reject", !ok, cfg_rej);
  endtask
  // One scan; an error is acknowledged so the next scan stands alone.
  task automatic scan(logic [N-1:0] p, logic on, pn, er);
    scan_beams = p;
    scan_valid = 1'b1;
    @(negedge clk);
    scan_valid = 1'b0;
    scan_beams = ~p;
    // The result pulse stands only in the cycle after the judging edge.
    @(negedge clk);
    chk("result_valid", 1'b1, res_v);
    chk("safety_out", on, safety);
    chk("error_state", er, err_st);
    if (!er) chk("penetration", pn, pen);
    @(negedge clk);
    chk("motion_on", on, motion_on);
    if (er) begin
      error_ack = 1'b1;
      @(negedge clk);
      error_ack = 1'b0;
      chk("error_ack", 1'b0, err_st);
    end
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_reset();
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk("rst_safety", 1'b0, safety);
    chk("rst_error", 1'b1, err_st);
    chk("rst_cfg", 1'b0, cfg_v);
  endtask
  task automatic t_sync();
    cfg(16'h4002, '0, FBB_MODE_FIXED, 1'b0);
    cfg(16'h0002, '0, FBB_MODE_FIXED, 1'b1);
    scan(16'h0002, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_plain();
    cfg(16'h01c0, '0, FBB_MODE_FIXED, 1'b1);
    scan(16'h01c0, 1'b1, 1'b0, 1'b0);
    scan(16'h03c0, 1'b0, 1'b1, 1'b0);
    scan(16'h81c0, 1'b0, 1'b1, 1'b0);
    scan(16'h00c0, 1'b0, 1'b0, 1'b1);
    scan(16'h0380, 1'b0, 1'b1, 1'b1);
    scan(16'h01c0, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_areas();
    cfg(16'h1554, '0, FBB_MODE_FIXED, 1'b1);
    scan(16'h1554, 1'b1, 1'b0, 1'b0);
    scan(16'h1556, 1'b0, 1'b1, 1'b0);
    cfg(16'h06c0, '0, FBB_MODE_FIXED, 1'b1);
    scan(16'h07c0, 1'b0, 1'b1, 1'b1);
  endtask
  // Teach takes the last captured scan as the mask.
  task automatic t_teach();
    scan(16'h0c00, 1'b0, 1'b1, 1'b1);
    teach_req = 1'b1;
    @(negedge clk);
    teach_req = 1'b0;
    @(negedge clk);
    chk("teach_cfg", 1'b1, cfg_v);
    chk("teach_rej", 1'b0, cfg_rej);
    scan(16'h0c00, 1'b1, 1'b0, 1'b0);
    scan(16'h0000, 1'b0, 1'b0, 1'b1);
  endtask
  // Shift down, up, grow, shrink, shift two, one beam, grow both.
  task automatic t_edge();
    logic [N-1:0] pat [7];
    logic [6:0]   on, pn, er;
    pat = '{16'h00e0, 16'h0380, 16'h03c0, 16'h0180,
            16'h0300, 16'h0100, 16'h03e0};
    on = 7'b1111000;
    pn = 7'b0000001;
    er = 7'b0000110;
    cfg(16'h01c0, 16'h01c0, FBB_MODE_EDGE, 1'b1);
    for (int i = 0; i < 7; i++) begin
      scan(pat[i], on[6-i], pn[6-i], er[6-i]);
    end
    cfg(16'h0100, '0, FBB_MODE_EDGE, 1'b0);
  endtask
  task automatic t_gap();
    cfg(16'h06c0, '0, FBB_MODE_EDGE, 1'b1);
    cfg(16'h06c0, 16'h0080, FBB_MODE_EDGE, 1'b0);
    cfg(16'h06c0, 16'h0280, FBB_MODE_EDGE, 1'b0);
    cfg(16'h0cc0, 16'h0080, FBB_MODE_EDGE, 1'b1);
    cfg(16'h18c0, 16'h0880, FBB_MODE_EDGE, 1'b1);
    scan(16'h1fc0, 1'b0, 1'b1, 1'b1);
  endtask
  // ==========================================
  // Main sequence; a second reset mid-run closes it.
  initial begin
    nrst = 1'b0;
    scan_valid = 1'b0;
    scan_beams = '0;
    teach_req = 1'b0;
    link_wr = 1'b0;
    link_mask = '0;
    link_move = '0;
    link_mode = FBB_MODE_FIXED;
    error_ack = 1'b0;
    num_errors = 0;
    checks = 0;
    cyc = 0;
    t_reset();
    t_sync();
    t_plain();
    t_areas();
    t_teach();
    t_edge();
    t_gap();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
